// ### design/partition_tag_map.svh
// register offsets, field positions, reset values and build constants for the tag register group
`ifndef PARTITION_TAG_MAP_SVH
`define PARTITION_TAG_MAP_SVH

// ==========================================================
// register offsets (byte addresses)
`define TAG_LIMIT_IDENT_OFF       12'h0130
`define DEVICE_ACCESS_TAG_OFF     12'h0138
`define BYPASS_TAG_OFF            12'h013c
`define VM_SELECT_OFF             12'h0180
`define CMD_QUEUE_IDENT_OFF       12'h0190
`define TAG_CTRL_OFF              12'h01f0

// ==========================================================
// field positions
`define UPDATE_BIT                31
`define MONGRP_HI                 23
`define MONGRP_LO                 16
`define PARTITION_IDENTIFIER_HI                 15
`define PARTITION_IDENTIFIER_LO                 0
`define PAGES_LOG2_HI             27
`define PAGES_LOG2_LO             24
`define QUEUES_LOG2_HI            19
`define QUEUES_LOG2_LO            16
`define VIRTUAL_MACHINE_ID_WIDE_HI              15
`define VIRTUAL_MACHINE_ID_WIDE_LO              8
`define CTRL_XLATE_EN_BIT         0
`define CTRL_XCHK_BIT             1
`define CTRL_VRUN_BIT             2

// ==========================================================
// reset values and limits
`define MONGRP_RESET              8'h00
`define PARTITION_IDENTIFIER_RESET              16'h0000
`define VIRTUAL_MACHINE_ID_RESET                16'h0000
`define LOG2_LIMIT                4'h8
`define UPDATE_SETTLE_CYCLES      4'h3

`endif

// ### design/partition_tag_pkg.sv
// types shared by the tag register group
package partition_tag_pkg;

   // one partition tag pair
   typedef struct packed {
      logic [7:0]  monitoringGroup;
      logic [15:0] partitionIdentifier;
   } tag_pair_t;

   // register port request
   typedef struct packed {
      logic [11:0] addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } reg_req_t;

   // update settle state
   typedef enum logic [1:0] {
      UPD_IDLE   = 2'b00,
      UPD_SETTLE = 2'b01,
      UPD_DONE   = 2'b10
   } upd_state_t;

endpackage

// ### design/partition_tag_config_regs.sv
// partition tag configuration registers and tag selection for outgoing accesses
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`include "partition_tag_map.svh"

module partition_tag_config_regs
   import partition_tag_pkg::*;
#(
   parameter logic        TAGGING_SUPPORT = 1'b1,
   parameter logic        VXLATE_SUPPORT  = 1'b1,
   parameter logic        ENHANCED_CMD_QUEUE_SUPPORT_SUPPORT   = 1'b1,
   parameter logic        WIDE_VIRTUAL_MACHINE_ID       = 1'b1,
   parameter logic [7:0]  MONGRP_LIMIT    = 8'h0f,
   parameter logic [15:0] PARTITION_IDENTIFIER_LIMIT    = 16'h0034,
   parameter logic [3:0]  PAGES_LOG2      = 4'h1,
   parameter logic [3:0]  QUEUES_LOG2     = 4'h2
)(
   input  wire logic        mclk,
   input  wire logic        rst_n,
   input  wire logic [11:0] regAddr,
   input  wire logic [31:0] regWdata,
   input  wire logic        regWr,
   input  wire logic        regRd,
   output      logic [31:0] regRdata,
   input  wire logic        clientBypassReq,
   input  wire logic        clientTranslated,
   input  wire logic [7:0]  entryMonGroup,
   input  wire logic [15:0] entryPartId,
   input  wire logic        vxlateReq,
   input  wire logic        entryVmTagged,
   input  wire logic [15:0] entryStage2VmId,
   output      logic [7:0]  ownAccessMonGroup,
   output      logic [15:0] ownAccessPartId,
   output      logic [7:0]  clientMonGroup,
   output      logic [15:0] clientPartId,
   output      logic        vxlateDeny,
   output      logic        vxlateValid,
   output      logic        globalXlateEnable,
   output      logic        translatedCheckCtrl,
   output      logic        vxlateRun
);

   // ==========================================================
   // helper functions

   // width of a field given its maximum value: highest set bit plus one
   function automatic logic [4:0] tagWidth(input logic [15:0] limit);
      logic [4:0] w;
      w = 5'd0;
      for (int i = 0; i < 16; i++)
      begin
         if (limit[i])
         begin
            w = 5'(i + 1);
         end
      end
      return w;
   endfunction

   // mask of implemented bits for a field of the given width
   function automatic logic [15:0] widthMask(input logic [4:0] w);
      logic [16:0] m;
      m = (17'h0_0001 << w) - 17'h0_0001;
      return m[15:0];
   endfunction

   // ==========================================================
   // derived capability constants
   wire logic [4:0]  mgWidth = tagWidth({8'h00, MONGRP_LIMIT});
   wire logic [4:0]  piWidth = tagWidth(PARTITION_IDENTIFIER_LIMIT);
   wire logic [15:0] mgFull  = widthMask(mgWidth);
   wire logic [7:0]  mgMask  = mgFull[7:0];
   wire logic [15:0] piMask  = widthMask(piWidth);
   // limit values clamped to the architectural ceiling of eight
   wire logic [3:0]  pagesLog2  = (PAGES_LOG2 > `LOG2_LIMIT) ? `LOG2_LIMIT : PAGES_LOG2;
   wire logic [3:0]  queuesLog2 = (QUEUES_LOG2 > `LOG2_LIMIT) ? `LOG2_LIMIT : QUEUES_LOG2;

   // strip unsupported upper bits from a tag pair; masks must be declared above
   function automatic tag_pair_t clipTag(input logic [31:0] d);
      tag_pair_t t;
      t.monitoringGroup     = d[`MONGRP_HI:`MONGRP_LO] & mgMask;
      t.partitionIdentifier = d[`PARTITION_IDENTIFIER_HI:`PARTITION_IDENTIFIER_LO] & piMask;
      return t;
   endfunction

   // ==========================================================
   // storage
   tag_pair_t  devTag_q, devTag_d;
   tag_pair_t  bypTag_q, bypTag_d;
   logic       devUpd_q, devUpd_d;
   logic       bypUpd_q, bypUpd_d;
   upd_state_t devSt_q, devSt_d;
   upd_state_t bypSt_q, bypSt_d;
   logic [3:0] devCnt_q, devCnt_d;
   logic [3:0] bypCnt_q, bypCnt_d;
   tag_pair_t  devLive_q;   // tags actually applied to own accesses
   tag_pair_t  bypLive_q;   // tags actually applied to bypass traffic
   logic [15:0] vmSel_q, vmSel_d;
   logic [2:0]  ctrl_q, ctrl_d;
   logic [31:0] rdata_d;
   tag_pair_t   clientTag_d;
   logic        deny_d;

   // ==========================================================
   // address decode
   wire logic hitLimit = TAGGING_SUPPORT && (regAddr == `TAG_LIMIT_IDENT_OFF);
   wire logic hitDev   = TAGGING_SUPPORT && (regAddr == `DEVICE_ACCESS_TAG_OFF);
   wire logic hitByp   = TAGGING_SUPPORT && (regAddr == `BYPASS_TAG_OFF);
   wire logic hitVm    = VXLATE_SUPPORT && (regAddr == `VM_SELECT_OFF);
   wire logic hitIdent = ENHANCED_CMD_QUEUE_SUPPORT_SUPPORT && (regAddr == `CMD_QUEUE_IDENT_OFF);
   wire logic hitCtrl  = (regAddr == `TAG_CTRL_OFF);
   wire logic wUpd     = regWdata[`UPDATE_BIT];

   // a tag write is taken only when idle and it asks for an update
   wire logic devTake = regWr && hitDev && !devUpd_q && wUpd;
   wire logic bypTake = regWr && hitByp && !bypUpd_q && wUpd;
   // selector frozen while a virtual translation runs
   wire logic vmTake  = regWr && hitVm && !ctrl_q[`CTRL_VRUN_BIT];

   // ==========================================================
   // device-access tag register next state
   always_comb
   begin
      devTag_d = devTag_q;
      devUpd_d = devUpd_q;
      devSt_d  = devSt_q;
      devCnt_d = devCnt_q;
      case (devSt_q)
         UPD_IDLE:
         begin
            if (devTake)
            begin
               devTag_d = clipTag(regWdata); // visible on readback at once
               devUpd_d = 1'b1;
               devCnt_d = `UPDATE_SETTLE_CYCLES;
               devSt_d  = UPD_SETTLE;
            end
         end
         UPD_SETTLE:
         begin
            // drain window so in-flight accesses finish with the old tags
            if (devCnt_q == 4'h0)
            begin
               devSt_d = UPD_DONE;
            end
            else
            begin
               devCnt_d = devCnt_q - 4'h1;
            end
         end
         UPD_DONE:
         begin
            devUpd_d = 1'b0; // live copy already loaded
            devSt_d  = UPD_IDLE;
         end
         default:
         begin
            devSt_d = UPD_IDLE;
         end
      endcase
   end

   // ==========================================================
   // bypass tag register next state
   always_comb
   begin
      bypTag_d = bypTag_q;
      bypUpd_d = bypUpd_q;
      bypSt_d  = bypSt_q;
      bypCnt_d = bypCnt_q;
      case (bypSt_q)
         UPD_IDLE:
         begin
            if (bypTake)
            begin
               bypTag_d = clipTag(regWdata);
               bypUpd_d = 1'b1;
               bypCnt_d = `UPDATE_SETTLE_CYCLES;
               bypSt_d  = UPD_SETTLE;
            end
         end
         UPD_SETTLE:
         begin
            if (bypCnt_q == 4'h0)
            begin
               bypSt_d = UPD_DONE;
            end
            else
            begin
               bypCnt_d = bypCnt_q - 4'h1;
            end
         end
         UPD_DONE:
         begin
            bypUpd_d = 1'b0;
            bypSt_d  = UPD_IDLE;
         end
         default:
         begin
            bypSt_d = UPD_IDLE;
         end
      endcase
   end

   // ==========================================================
   // selector and control bits
   assign vmSel_d = vmTake ? {regWdata[15:8] & {8{WIDE_VIRTUAL_MACHINE_ID}}, regWdata[7:0]}
                           : vmSel_q;
   assign ctrl_d  = (regWr && hitCtrl) ? regWdata[2:0] : ctrl_q;

   // ==========================================================
   // read mux; unmapped or absent registers read zero
   always_comb
   begin
      rdata_d = 32'h0000_0000;
      if (hitLimit)
      begin
         rdata_d = {8'h00, MONGRP_LIMIT, PARTITION_IDENTIFIER_LIMIT};
      end
      else if (hitDev)
      begin
         rdata_d = {devUpd_q, 7'h00, devTag_q};
      end
      else if (hitByp)
      begin
         rdata_d = {bypUpd_q, 7'h00, bypTag_q};
      end
      else if (hitVm)
      begin
         rdata_d = {16'h0000, vmSel_q};
      end
      else if (hitIdent)
      begin
         rdata_d = {4'h0, pagesLog2, 4'h0, queuesLog2, 16'h0000};
      end
      else if (hitCtrl)
      begin
         rdata_d = {29'h0000_0000, ctrl_q};
      end
   end

   // ==========================================================
   // client tag selection and virtual translation check
   always_comb
   begin
      // bypass when translation off, or pre-translated with the check off
      if (!ctrl_q[`CTRL_XLATE_EN_BIT]
          || (clientTranslated && !ctrl_q[`CTRL_XCHK_BIT]))
      begin
         clientTag_d = bypLive_q;
      end
      else
      begin
         clientTag_d.monitoringGroup     = entryMonGroup;
         clientTag_d.partitionIdentifier = entryPartId;
      end
   end
   assign deny_d = !entryVmTagged || (entryStage2VmId != vmSel_q);

   // ==========================================================
   // state registers
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         devTag_q <= '{`MONGRP_RESET, `PARTITION_IDENTIFIER_RESET};
         bypTag_q <= '{`MONGRP_RESET, `PARTITION_IDENTIFIER_RESET};
         devUpd_q <= 1'b0;
         bypUpd_q <= 1'b0;
         devSt_q  <= UPD_IDLE;
         bypSt_q  <= UPD_IDLE;
         devCnt_q <= 4'h0;
         bypCnt_q <= 4'h0;
         devLive_q <= '{`MONGRP_RESET, `PARTITION_IDENTIFIER_RESET};
         bypLive_q <= '{`MONGRP_RESET, `PARTITION_IDENTIFIER_RESET};
         vmSel_q  <= `VIRTUAL_MACHINE_ID_RESET;
         ctrl_q   <= 3'h0;
      end
      else
      begin
         devTag_q <= devTag_d;
         bypTag_q <= bypTag_d;
         devUpd_q <= devUpd_d;
         bypUpd_q <= bypUpd_d;
         devSt_q  <= devSt_d;
         bypSt_q  <= bypSt_d;
         devCnt_q <= devCnt_d;
         bypCnt_q <= bypCnt_d;
         // live copy loads at settle end, before the flag drops
         if (devSt_q == UPD_SETTLE && devCnt_q == 4'h0)
         begin
            devLive_q <= devTag_q;
         end
         if (bypSt_q == UPD_SETTLE && bypCnt_q == 4'h0)
         begin
            bypLive_q <= bypTag_q;
         end
         vmSel_q  <= vmSel_d;
         ctrl_q   <= ctrl_d;
      end
   end

   // ==========================================================
   // registered outputs
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         regRdata            <= 32'h0000_0000;
         ownAccessMonGroup   <= `MONGRP_RESET;
         ownAccessPartId     <= `PARTITION_IDENTIFIER_RESET;
         clientMonGroup      <= `MONGRP_RESET;
         clientPartId        <= `PARTITION_IDENTIFIER_RESET;
         vxlateDeny          <= 1'b0;
         vxlateValid         <= 1'b0;
         globalXlateEnable   <= 1'b0;
         translatedCheckCtrl <= 1'b0;
         vxlateRun           <= 1'b0;
      end
      else
      begin
         regRdata            <= regRd ? rdata_d : 32'h0000_0000;
         ownAccessMonGroup   <= devLive_q.monitoringGroup;
         ownAccessPartId     <= devLive_q.partitionIdentifier;
         clientMonGroup      <= clientTag_d.monitoringGroup;
         clientPartId        <= clientTag_d.partitionIdentifier;
         vxlateValid         <= vxlateReq && VXLATE_SUPPORT;
         vxlateDeny          <= vxlateReq && VXLATE_SUPPORT && deny_d;
         globalXlateEnable   <= ctrl_q[`CTRL_XLATE_EN_BIT];
         translatedCheckCtrl <= ctrl_q[`CTRL_XCHK_BIT];
         vxlateRun           <= ctrl_q[`CTRL_VRUN_BIT];
      end
   end

endmodule

// ### tb/partition_tag_config_regs_monitor.sv
// concurrent checks on the ports of the tag register group
`timescale 1ns/1ps
`include "partition_tag_map.svh"
module partition_tag_config_regs_monitor #(
   parameter logic [7:0]  MONGRP_LIMIT = 8'h0f,
   parameter logic [15:0] PARTITION_IDENTIFIER_LIMIT = 16'h0034,
   parameter logic [3:0]  PAGES_LOG2   = 4'h1,
   parameter logic [3:0]  QUEUES_LOG2  = 4'h2
)(
   input wire logic        mclk,
   input wire logic        rst_n,
   input wire logic [11:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic        regWr,
   input wire logic        regRd,
   input wire logic [31:0] regRdata,
   input wire logic        clientTranslated,
   input wire logic [7:0]  entryMonGroup,
   input wire logic [15:0] entryPartId,
   input wire logic        vxlateReq,
   input wire logic        entryVmTagged,
   input wire logic [7:0]  ownAccessMonGroup,
   input wire logic [15:0] ownAccessPartId,
   input wire logic [7:0]  clientMonGroup,
   input wire logic [15:0] clientPartId,
   input wire logic        vxlateDeny,
   input wire logic        vxlateValid,
   input wire logic        globalXlateEnable
);
   // ==========================================================
   // helper: cycles since the last flagged write to the device tag register
   logic [3:0] sinceOwnWr_q;
   logic [3:0] sinceOwnWr_d;
   assign sinceOwnWr_d = (regWr && regAddr == `DEVICE_ACCESS_TAG_OFF && regWdata[31]) ? 4'h0 :
                         (sinceOwnWr_q == 4'hf) ? 4'hf : sinceOwnWr_q + 4'h1;
   // saturates so an idle bus never wraps back into the window
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n) sinceOwnWr_q <= 4'hf;
      else sinceOwnWr_q <= sinceOwnWr_d;
   end

   // ==========================================================
   // assertions
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   a_rdata_idle_zero: assert property (!$past(regRd) |-> regRdata == 32'h0000_0000)
      else $error("read data not zero outside read cycle");
   a_limit_ident: assert property ($past(regRd) && $past(regAddr) == 12'h0130 |->
      regRdata == {8'h00, MONGRP_LIMIT, PARTITION_IDENTIFIER_LIMIT}) else $error("tag limit ident wrong");
   a_queue_ident: assert property ($past(regRd) && $past(regAddr) == 12'h0190 |->
      regRdata == {4'h0, PAGES_LOG2, 4'h0, QUEUES_LOG2, 16'h0000})
      else $error("queue ident wrong");
   a_tag_reserved_zero: assert property ($past(regRd) && ($past(regAddr) == 12'h0138 ||
      $past(regAddr) == 12'h013c) |-> regRdata[30:24] == 7'h00) else $error("reserved bits set");
   a_vx_answer_once: assert property (vxlateReq |=> vxlateValid ##1 !vxlateValid)
      else $error("vm translate answer timing wrong");
   a_vx_untagged_deny: assert property (vxlateReq && !entryVmTagged |=> vxlateDeny)
      else $error("untagged entry not denied");
   a_client_entry_tags: assert property (globalXlateEnable && !clientTranslated |=>
      !globalXlateEnable || (clientMonGroup == $past(entryMonGroup) &&
      clientPartId == $past(entryPartId))) else $error("client tags not from entry");
   a_own_tags_caused: assert property ($changed(ownAccessMonGroup) ||
      $changed(ownAccessPartId) |-> sinceOwnWr_q <= 4'ha) else $error("own tags moved unasked");
   // main scenarios
   c_vx_deny: cover property (vxlateValid && vxlateDeny);
   c_vx_grant: cover property (vxlateValid && !vxlateDeny);
   c_own_write: cover property (regWr && regAddr == 12'h0138 && regWdata[31]);
endmodule

// ### tb/partition_tag_config_regs_tb.sv
// self-checking bench for the tag register group
`timescale 1ns/1ps
`define CHECK(nm, exp, got) begin checksDone++; if ((got) !== (exp)) begin miscompares++; \
   $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module partition_tag_config_regs_tb;
   logic        mclk = 0, rst_n = 0, regWr = 0, regRd = 0, clientTranslated = 0;
   logic        vxlateReq = 0, entryVmTagged = 0, vxlateDeny, vxlateValid, vxlateRun;
   logic        globalXlateEnable, translatedCheckCtrl;
   logic [11:0] regAddr = 0;
   logic [31:0] regWdata = 0, regRdata, rd;
   logic [7:0]  entryMonGroup = 0, ownAccessMonGroup, clientMonGroup;
   logic [15:0] entryPartId = 0, entryStage2VmId = 0, ownAccessPartId, clientPartId;
   logic [1:0]  ctl;
   int          miscompares = 0, checksDone = 0, cycles = 0;

   partition_tag_config_regs i_partition_tag_config_regs (.mclk(mclk), .rst_n(rst_n),
      .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
      .regRdata(regRdata), .clientBypassReq(1'b0), .clientTranslated(clientTranslated),
      .entryMonGroup(entryMonGroup), .entryPartId(entryPartId), .vxlateReq(vxlateReq),
      .entryVmTagged(entryVmTagged), .entryStage2VmId(entryStage2VmId),
      .ownAccessMonGroup(ownAccessMonGroup), .ownAccessPartId(ownAccessPartId),
      .clientMonGroup(clientMonGroup), .clientPartId(clientPartId), .vxlateDeny(vxlateDeny),
      .vxlateValid(vxlateValid), .globalXlateEnable(globalXlateEnable),
      .translatedCheckCtrl(translatedCheckCtrl), .vxlateRun(vxlateRun));

   // ==========================================================
   // clock, and a cycle ceiling far above the hundred or so cycles needed
   always #10 mclk = ~mclk;
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         miscompares++;
         finishTest();
      end
   end

   // ==========================================================
   // register port tasks
   task automatic wrReg(input logic [11:0] a, input logic [31:0] d);
      @(posedge mclk);
      regWr <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge mclk);
      regWr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rdReg(input logic [11:0] a);
      @(posedge mclk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge mclk);
      regRd <= 1'b0;
      #1 rd = regRdata;
   endtask
   task automatic chkReg(input logic [11:0] a, input logic [31:0] exp);
      rdReg(a);
      `CHECK("register", exp, rd)
   endtask
   // poll the update flag without comparing, bounded so a stuck flag fails
   task automatic waitClear(input logic [11:0] a, input logic [31:0] exp);
      for (int n = 0; n < 20 && (n == 0 || rd[31] !== 1'b0); n++)
         rdReg(a);
      `CHECK("flag clear", exp, rd)
   endtask
   task automatic finishTest();
      $display("checks %0d mismatches %0d", checksDone, miscompares);
      if (miscompares == 0 && checksDone > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // ==========================================================
   // main sequence
   initial
   begin
      repeat (3) @(posedge mclk);
      rst_n <= 1'b1;
      chkReg(12'h138, 32'h0000_0000);
      chkReg(12'h13c, 32'h0000_0000);
      wrReg(12'h130, 32'hffff_ffff);
      chkReg(12'h130, 32'h000f_0034);
      chkReg(12'h190, 32'h0102_0000);
      chkReg(12'h100, 32'h0000_0000);
      wrReg(12'h138, 32'h0005_0003);
      chkReg(12'h138, 32'h0000_0000);
      wrReg(12'h138, 32'h8005_0003);
      wrReg(12'h138, 32'h8001_0001);
      chkReg(12'h138, 32'h8005_0003);
      waitClear(12'h138, 32'h0005_0003);
      `CHECK("own group", 8'h05, ownAccessMonGroup)
      `CHECK("own partition", 16'h0003, ownAccessPartId)
      wrReg(12'h138, 32'hfff9_ffc6);
      chkReg(12'h138, 32'h8009_0006);
      waitClear(12'h138, 32'h0009_0006);
      wrReg(12'h13c, 32'h8007_000a);
      chkReg(12'h13c, 32'h8007_000a);
      waitClear(12'h13c, 32'h0007_000a);
      // each bypass reason and the entry-tag cases, untranslated traffic in the first two passes, translated in the last two
      for (int i = 0; i < 4; i++)
      begin
         ctl = {i == 3, i != 0};
         wrReg(12'h1f0, {30'h0, ctl});
         @(posedge mclk);
         clientTranslated <= (i >= 2);
         entryMonGroup <= 8'h0c;
         entryPartId <= 16'h0021;
         repeat (3) @(posedge mclk);
         #1;
         `CHECK("enable", ctl[0], globalXlateEnable)
         `CHECK("check ctrl", ctl[1], translatedCheckCtrl)
         if (!ctl[0] || (i >= 2 && !ctl[1]))
            `CHECK("client part", 24'h07_000a, {clientMonGroup, clientPartId})
         else
            `CHECK("client part", 24'h0c_0021, {clientMonGroup, clientPartId})
      end
      wrReg(12'h1f0, 32'h0000_0000);
      wrReg(12'h180, 32'hffff_1234);
      chkReg(12'h180, 32'h0000_1234);
      wrReg(12'h1f0, 32'h0000_0004);
      wrReg(12'h180, 32'h0000_5678);
      chkReg(12'h180, 32'h0000_1234);
      `CHECK("run", 1'b1, vxlateRun)
      // grant, mismatching id, untagged entry
      for (int i = 0; i < 3; i++)
      begin
         @(posedge mclk);
         vxlateReq <= 1'b1;
         entryVmTagged <= (i != 2);
         entryStage2VmId <= (i == 1) ? 16'h1235 : 16'h1234;
         @(posedge mclk);
         vxlateReq <= 1'b0;
         #1;
         `CHECK("vm answer", {1'b1, i != 0}, {vxlateValid, vxlateDeny})
      end
      wrReg(12'h1f0, 32'h0000_0000);
      wrReg(12'h180, 32'h0000_5678);
      chkReg(12'h180, 32'h0000_5678);
      `CHECK("run", 1'b0, vxlateRun)
      finishTest();
   end
endmodule

bind partition_tag_config_regs partition_tag_config_regs_monitor #(
   .MONGRP_LIMIT(MONGRP_LIMIT), .PARTITION_IDENTIFIER_LIMIT(PARTITION_IDENTIFIER_LIMIT),
   .PAGES_LOG2(PAGES_LOG2), .QUEUES_LOG2(QUEUES_LOG2)) i_mon (.mclk(mclk), .rst_n(rst_n),
   .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
   .clientTranslated(clientTranslated), .entryMonGroup(entryMonGroup),
   .entryPartId(entryPartId), .vxlateReq(vxlateReq), .entryVmTagged(entryVmTagged),
   .ownAccessMonGroup(ownAccessMonGroup), .ownAccessPartId(ownAccessPartId),
   .clientMonGroup(clientMonGroup), .clientPartId(clientPartId), .vxlateDeny(vxlateDeny),
   .vxlateValid(vxlateValid), .globalXlateEnable(globalXlateEnable));
